// ### pkg/ucbs_pkg.sv
// Purpose: constants for the serial port configuration, status and baud logic
// Assumes: 8-bit CPU data bus, byte-wide registers at absolute addresses
// Notes: all offsets, field positions and reset values live here
// Behaviour
// - Full duplex, one byte after start bit
// - Enable bits 7/6 select stop, rx, tx, both
// - Parity field: none, zero, odd, even
// - Length bit: 7 or 8 data bits
// - Stop bit: one or two transmitted stops
// - Receiver checks only one stop bit
// - Mask bit suppresses completion interrupt on error
// - Mode register bit/byte writable, resets 00H
// - Status register byte read only, resets 00H
// - Odd/even parity mismatch sets parity error flag
// - Missing stop bit sets framing error flag
// - Unread previous frame sets overrun flag
// - Overrun repeats until receive buffer read
// - Prescaler field selects clock over 2^(n+1)
// - Divider field divides by 16 plus k
// - Bit rate is clock/(2^(n+2)*(k+16))
// - Baud register byte write, resets 00H, bit7 zero
// - Status reads 04H, 02H, 01H per error
// - Status clears on buffer read or next frame
package ucbs_pkg;
    localparam logic [15:0] ADDR_MODE = 16'hFFA0;
    localparam logic [15:0] ADDR_STATUS = 16'hFFA1;
    localparam logic [15:0] ADDR_BAUD = 16'hFFA2;
    localparam logic [15:0] ADDR_RXBUF = 16'hFFA3;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] BAUD_RESET = 8'h00;
    localparam logic [7:0] MODE_WMASK = 8'hFE;
    localparam logic [7:0] BAUD_WMASK = 8'h7F;
    localparam int MODE_TXE = 7;
    localparam int MODE_RXE = 6;
    localparam int MODE_PAR_HI = 5;
    localparam int MODE_PAR_LO = 4;
    localparam int MODE_CL = 3;
    localparam int MODE_SL = 2;
    localparam int MODE_ERRMASK = 1;
    localparam int STAT_PE = 2;
    localparam int STAT_FE = 1;
    localparam int STAT_OVE = 0;
    localparam int BAUD_PS_HI = 6;
    localparam int BAUD_PS_LO = 4;
    localparam int BAUD_DIV_HI = 3;
    localparam int BAUD_DIV_LO = 0;
    localparam logic [4:0] DIV_BASE = 5'h10;
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam logic [1:0] PAR_EVEN = 2'h3;
    localparam int DATA_W = 8;
    localparam int TX_FIFO_DEPTH = 8;
    localparam int PRESC_W = 8;
endpackage

// ### hdl/ucbs_fifo.sv
// Purpose: small synchronous FIFO in the transmit data path
// Assumes: one clock, asynchronous active-low reset
// Notes: ready and empty are registered
`timescale 1ns/1ps
`default_nettype none
module ucbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] cnt_q;
    logic empty_q;
    logic push;
    logic pop;
    logic [AW:0] cnt_d;

    assign push = in_valid && in_ready;
    assign pop = out_ready && !empty_q;
    assign out_valid = !empty_q;
    assign out_data = mem[rd_ptr_q];

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    // Pointers wrap by hand so DEPTH need not be a power of two
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b1;
            empty_q <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            cnt_q <= cnt_d;
            in_ready <= (cnt_d != (AW+1)'(DEPTH));
            empty_q <= (cnt_d == '0);
        end
    end
endmodule
`default_nettype wire

// ### hdl/ucbs_top.sv
// Purpose: serial port mode, error status, baud generator and framing
// Assumes: CPU bus strobes are one-cycle pulses synchronous to core_clk
// Notes: serial_in_pin is taken as already synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module ucbs_top #(
    parameter int FIFO_DEPTH = ucbs_pkg::TX_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_bit_wr,
    input wire logic [2:0] cpu_bit_sel,
    input wire logic cpu_bit_val,
    input wire logic cpu_rd,
    output logic [7:0] cpu_rdata,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_out_en,
    output logic serial_in_en,
    output logic tx_done,
    output logic rx_done,
    output logic rx_err
);
    typedef enum logic [4:0] {
        UCBS_IDLE = 5'b00001,
        UCBS_START = 5'b00010,
        UCBS_DATA = 5'b00100,
        UCBS_PAR = 5'b01000,
        UCBS_STOP = 5'b10000
    } ucbs_state_t;

    logic [7:0] mode_q;
    logic [7:0] status_q;
    logic [7:0] baud_q;
    logic [7:0] rx_buf_q;
    logic rx_full_q;
    logic [ucbs_pkg::PRESC_W-1:0] presc_q;
    logic fsck_tick;
    logic [4:0] div_lim;
    logic [1:0] par_mode;
    logic [2:0] last_bit;
    logic mode_wr;
    logic baud_wr;
    logic buf_rd;
    logic tx_en;
    logic rx_en;

    ucbs_state_t tx_state_q;
    logic [4:0] tx_cnt_q;
    logic tx_half_q;
    logic [7:0] tx_sh_q;
    logic [2:0] tx_idx_q;
    logic tx_par_q;
    logic tx_stop2_q;
    logic tx_bit_end;
    logic [7:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    ucbs_state_t rx_state_q;
    logic [4:0] rx_cnt_q;
    logic rx_half_q;
    logic [7:0] rx_sh_q;
    logic [2:0] rx_idx_q;
    logic rx_half_end;
    logic rx_bit_end;
    logic rx_frame_end;
    logic rx_pe;

    // Parity over valid character bits
    function automatic logic ucbs_parity(input logic [7:0] d, input logic cl8,
                                         input logic [1:0] pm);
        logic ones;
        ones = ^{d[7] & cl8, d[6:0]};
        case (pm)
            ucbs_pkg::PAR_ODD: ucbs_parity = ~ones;
            ucbs_pkg::PAR_EVEN: ucbs_parity = ones;
            default: ucbs_parity = 1'b0;
        endcase
    endfunction

    // Half bit ends at count 16+k-1 on a source tick
    function automatic logic ucbs_half_end(input logic [4:0] cnt, input logic [4:0] lim,
                                           input logic tick);
        ucbs_half_end = tick && (cnt == lim);
    endfunction

    assign tx_en = mode_q[ucbs_pkg::MODE_TXE];
    assign rx_en = mode_q[ucbs_pkg::MODE_RXE];
    assign par_mode = mode_q[ucbs_pkg::MODE_PAR_HI:ucbs_pkg::MODE_PAR_LO];
    assign last_bit = mode_q[ucbs_pkg::MODE_CL] ? 3'h7 : 3'h6;
    assign mode_wr = (cpu_wr || cpu_bit_wr) && cpu_addr == ucbs_pkg::ADDR_MODE;
    assign baud_wr = cpu_wr && cpu_addr == ucbs_pkg::ADDR_BAUD;
    assign buf_rd = cpu_rd && cpu_addr == ucbs_pkg::ADDR_RXBUF;

    // Register writes; bit writes only reach the mode register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= ucbs_pkg::MODE_RESET;
            baud_q <= ucbs_pkg::BAUD_RESET;
        end else begin
            if (mode_wr && cpu_wr) begin
                mode_q <= cpu_wdata & ucbs_pkg::MODE_WMASK;
            end else if (mode_wr) begin
                mode_q[cpu_bit_sel] <= cpu_bit_val & ucbs_pkg::MODE_WMASK[cpu_bit_sel];
            end
            if (baud_wr) begin
                baud_q <= cpu_wdata & ucbs_pkg::BAUD_WMASK;
            end
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cpu_rdata <= 8'h00;
        end else if (cpu_rd) begin
            case (cpu_addr)
                ucbs_pkg::ADDR_MODE: cpu_rdata <= mode_q;
                ucbs_pkg::ADDR_STATUS: cpu_rdata <= status_q;
                ucbs_pkg::ADDR_BAUD: cpu_rdata <= baud_q;
                ucbs_pkg::ADDR_RXBUF: cpu_rdata <= rx_buf_q;
                default: cpu_rdata <= 8'h00;
            endcase
        end
    end

    // Prescaler: source tick every 2^n clocks, n = field + 1
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + 1'b1;
        end
    end

    always_comb begin
        logic [8:0] mask;
        mask = (9'h002 << baud_q[ucbs_pkg::BAUD_PS_HI:ucbs_pkg::BAUD_PS_LO]) - 9'h001;
        fsck_tick = ({1'b0, presc_q} & mask) == mask;
    end

    // Two half periods of 16+k source ticks make one bit
    assign div_lim = ucbs_pkg::DIV_BASE
        + {1'b0, baud_q[ucbs_pkg::BAUD_DIV_HI:ucbs_pkg::BAUD_DIV_LO]} - 5'h01;
    assign tx_bit_end = ucbs_half_end(tx_cnt_q, div_lim, fsck_tick) && tx_half_q;
    assign rx_half_end = ucbs_half_end(rx_cnt_q, div_lim, fsck_tick);
    assign rx_bit_end = rx_half_end && rx_half_q;

    ucbs_fifo #(
        .WIDTH(ucbs_pkg::DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .core_clk(core_clk),
        .resetn(resetn),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    assign fifo_pop = tx_en && fifo_valid && tx_state_q == UCBS_IDLE;

    // Transmit bit timer
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tx_cnt_q <= 5'h00;
            tx_half_q <= 1'b0;
        end else if (tx_state_q == UCBS_IDLE) begin
            tx_cnt_q <= 5'h00;
            tx_half_q <= 1'b0;
        end else if (fsck_tick) begin
            if (tx_cnt_q == div_lim) begin
                tx_cnt_q <= 5'h00;
                tx_half_q <= ~tx_half_q;
            end else begin
                tx_cnt_q <= tx_cnt_q + 5'h01;
            end
        end
    end

    // Transmit framing; runs alongside the receiver for full duplex
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tx_state_q <= UCBS_IDLE;
            tx_sh_q <= 8'h00;
            tx_idx_q <= 3'h0;
            tx_par_q <= 1'b0;
            tx_stop2_q <= 1'b0;
            serial_out_pin <= 1'b1;
            tx_done <= 1'b0;
        end else begin
            tx_done <= 1'b0;
            case (tx_state_q)
                UCBS_IDLE: begin
                    serial_out_pin <= 1'b1;
                    if (fifo_pop) begin
                        tx_sh_q <= fifo_data;
                        tx_par_q <= ucbs_parity(fifo_data, mode_q[ucbs_pkg::MODE_CL],
                                                par_mode);
                        tx_idx_q <= 3'h0;
                        tx_stop2_q <= mode_q[ucbs_pkg::MODE_SL];
                        serial_out_pin <= 1'b0;
                        tx_state_q <= UCBS_START;
                    end
                end
                UCBS_START: begin
                    if (tx_bit_end) begin
                        serial_out_pin <= tx_sh_q[0];
                        tx_state_q <= UCBS_DATA;
                    end
                end
                UCBS_DATA: begin
                    if (tx_bit_end) begin
                        tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                        tx_idx_q <= tx_idx_q + 3'h1;
                        if (tx_idx_q != last_bit) begin
                            serial_out_pin <= tx_sh_q[1];
                        end else if (par_mode != ucbs_pkg::PAR_NONE) begin
                            serial_out_pin <= tx_par_q;
                            tx_state_q <= UCBS_PAR;
                        end else begin
                            serial_out_pin <= 1'b1;
                            tx_state_q <= UCBS_STOP;
                        end
                    end
                end
                UCBS_PAR: begin
                    if (tx_bit_end) begin
                        serial_out_pin <= 1'b1;
                        tx_state_q <= UCBS_STOP;
                    end
                end
                UCBS_STOP: begin
                    if (tx_bit_end) begin
                        if (tx_stop2_q) begin
                            tx_stop2_q <= 1'b0;
                        end else begin
                            tx_done <= 1'b1;
                            tx_state_q <= UCBS_IDLE;
                        end
                    end
                end
                default: tx_state_q <= UCBS_IDLE;
            endcase
        end
    end

    // Receive timer restarts at the start edge and start check
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rx_cnt_q <= 5'h00;
            rx_half_q <= 1'b0;
        end else if (rx_state_q == UCBS_IDLE || (rx_state_q == UCBS_START && rx_half_end)) begin
            rx_cnt_q <= 5'h00;
            rx_half_q <= 1'b0;
        end else if (fsck_tick) begin
            if (rx_cnt_q == div_lim) begin
                rx_cnt_q <= 5'h00;
                rx_half_q <= ~rx_half_q;
            end else begin
                rx_cnt_q <= rx_cnt_q + 5'h01;
            end
        end
    end

    // Only one stop bit is examined, whatever the transmit stop length
    assign rx_frame_end = rx_state_q == UCBS_STOP && rx_bit_end && rx_en;

    // Receive framing; dropping the enable abandons the frame
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rx_state_q <= UCBS_IDLE;
            rx_sh_q <= 8'h00;
            rx_idx_q <= 3'h0;
            rx_pe <= 1'b0;
        end else if (!rx_en) begin
            rx_state_q <= UCBS_IDLE;
        end else begin
            case (rx_state_q)
                UCBS_IDLE: begin
                    if (!serial_in_pin) begin
                        rx_state_q <= UCBS_START;
                    end
                end
                UCBS_START: begin
                    if (rx_half_end) begin
                        rx_sh_q <= 8'h00;
                        rx_idx_q <= 3'h0;
                        rx_pe <= 1'b0;
                        rx_state_q <= serial_in_pin ? UCBS_IDLE : UCBS_DATA;
                    end
                end
                UCBS_DATA: begin
                    if (rx_bit_end) begin
                        rx_sh_q[rx_idx_q] <= serial_in_pin;
                        rx_idx_q <= rx_idx_q + 3'h1;
                        if (rx_idx_q == last_bit) begin
                            rx_state_q <= (par_mode == ucbs_pkg::PAR_NONE) ? UCBS_STOP
                                                                            : UCBS_PAR;
                        end
                    end
                end
                UCBS_PAR: begin
                    if (rx_bit_end) begin
                        // Zero parity is never checked
                        rx_pe <= par_mode[1] && (serial_in_pin != ucbs_parity(rx_sh_q,
                                 mode_q[ucbs_pkg::MODE_CL], par_mode));
                        rx_state_q <= UCBS_STOP;
                    end
                end
                UCBS_STOP: begin
                    if (rx_bit_end) begin
                        rx_state_q <= UCBS_IDLE;
                    end
                end
                default: rx_state_q <= UCBS_IDLE;
            endcase
        end
    end

    // Frame completion beats a same-cycle buffer read so no event is lost
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            status_q <= ucbs_pkg::STATUS_RESET;
            rx_buf_q <= 8'h00;
            rx_full_q <= 1'b0;
            rx_done <= 1'b0;
            rx_err <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            rx_err <= 1'b0;
            if (rx_frame_end) begin
                logic pe;
                logic fe;
                logic ove;
                pe = rx_pe;
                fe = !serial_in_pin;
                ove = rx_full_q && !buf_rd;
                status_q <= 8'h00;
                status_q[ucbs_pkg::STAT_PE] <= pe;
                status_q[ucbs_pkg::STAT_FE] <= fe;
                status_q[ucbs_pkg::STAT_OVE] <= ove;
                rx_buf_q <= rx_sh_q;
                rx_full_q <= 1'b1;
                rx_err <= pe || fe || ove;
                rx_done <= !((pe || fe || ove) && mode_q[ucbs_pkg::MODE_ERRMASK]);
            end else if (buf_rd) begin
                status_q <= 8'h00;
                rx_full_q <= 1'b0;
            end
        end
    end

    // Pin function flags follow the enables one cycle later
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            serial_out_en <= 1'b0;
            serial_in_en <= 1'b0;
        end else begin
            serial_out_en <= tx_en;
            serial_in_en <= rx_en;
        end
    end
endmodule
`default_nettype wire

// ### bench/ucbs_checker.sv
// Purpose: port assertions for the serial port configuration block
// Assumes: one clock, resetn low clears all state
// Notes: shadows the error mask bit from bus writes
`timescale 1ns/1ps
`default_nettype none
module ucbs_checker (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_bit_wr,
    input wire logic [2:0] cpu_bit_sel,
    input wire logic cpu_bit_val,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_rdata,
    input wire logic serial_out_pin,
    input wire logic serial_out_en,
    input wire logic serial_in_en,
    input wire logic tx_done,
    input wire logic rx_done,
    input wire logic rx_err
);
    logic mask_q;
    logic [7:0] run_q;
    logic at_mode;
    assign at_mode = cpu_addr == ucbs_pkg::ADDR_MODE;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mask_q <= 1'b0;
        end else if (at_mode && (cpu_wr || (cpu_bit_wr && cpu_bit_sel == 3'h1))) begin
            mask_q <= cpu_wr ? cpu_wdata[1] : cpu_bit_val;
        end
    end
    // Cycles since the line last moved; saturating
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            run_q <= 8'h00;
        end else if ($changed(serial_out_pin)) begin
            run_q <= 8'h00;
        end else if (run_q != 8'hFF) begin
            run_q <= run_q + 8'h01;
        end
    end
    stat_pad_a: assert property (cpu_rd && cpu_addr == ucbs_pkg::ADDR_STATUS |=>
        cpu_rdata[7:3] == 5'h00) else $error("status pad bits set");
    mode_bit0_a: assert property (cpu_rd && at_mode |=> !cpu_rdata[0])
        else $error("mode bit 0 reads one");
    baud_msb_a: assert property (cpu_rd && cpu_addr == ucbs_pkg::ADDR_BAUD |=>
        !cpu_rdata[7]) else $error("baud bit 7 reads one");
    enable_follow_a: assert property (cpu_wr && at_mode ##1 !cpu_wr && !cpu_bit_wr |=>
        {serial_out_en, serial_in_en} == $past(cpu_wdata[7:6], 2)) else $error("enables lag");
    rx_gated_a: assert property (rx_done |-> serial_in_en)
        else $error("receive while disabled");
    tx_idle_a: assert property (!serial_out_en |-> serial_out_pin)
        else $error("line low while disabled");
    err_mask_a: assert property (rx_err |-> rx_done == !mask_q)
        else $error("completion pulse ignores mask");
    stop_end_a: assert property (tx_done |-> serial_out_pin ##1 !tx_done)
        else $error("done pulse wrong");
    bit_len_a: assert property ($changed(serial_out_pin) && serial_out_en |->
        run_q >= 8'h3E) else $error("bit too short");
    clear_read_a: assert property (cpu_rd && cpu_addr == ucbs_pkg::ADDR_RXBUF
        ##1 !cpu_rd && !rx_done && !rx_err ##1 cpu_rd && cpu_addr == ucbs_pkg::ADDR_STATUS
        && !rx_done && !rx_err |=> cpu_rdata == 8'h00) else $error("status kept after read");
endmodule
bind ucbs_top ucbs_checker chk_i (.*);
`default_nettype wire

// ### bench/ucbs_remote.sv
// Purpose: remote asynchronous serial device on the far side of the pins
// Assumes: bench sets bit_clks and frame format while the line is idle
// Notes: a bad stop is cut to 3/4 bit so it cannot pass for a new start
`timescale 1ns/1ps
`default_nettype none
module ucbs_remote (
    input wire logic core_clk,
    input wire logic serial_out_pin,
    output var logic serial_in_pin
);
    int bit_clks = 64;
    int par_mode = 0;
    bit cl8 = 1'b1;
    bit sl2 = 1'b0;
    logic [10:0] got_q[$];
    initial serial_in_pin = 1'b1;
    task automatic hold(input logic b);
        serial_in_pin <= b;
        repeat (bit_clks) @(posedge core_clk);
    endtask
    task automatic send(input logic [7:0] d, input bit bad_par, input bit bad_stop);
        @(posedge core_clk);
        hold(1'b0);
        for (int i = 0; i < (cl8 ? 8 : 7); i++)
            hold(d[i]);
        if (par_mode != 0)
            hold((par_mode == 3 ? ^d : par_mode == 2 ? ~^d : 1'b0) ^ bad_par);
        serial_in_pin <= !bad_stop;
        repeat (bad_stop ? bit_clks * 3 / 4 : bit_clks) @(posedge core_clk);
        hold(1'b1);
    endtask
    // Decodes transmitted frames: {second stop, first stop, parity, data}
    always begin
        logic [10:0] r;
        @(negedge serial_out_pin);
        r = 11'h600;
        repeat (bit_clks / 2) @(posedge core_clk);
        for (int i = 0; i < (cl8 ? 8 : 7); i++) begin
            repeat (bit_clks) @(posedge core_clk);
            r[i] = serial_out_pin;
        end
        if (par_mode != 0) begin
            repeat (bit_clks) @(posedge core_clk);
            r[8] = serial_out_pin;
        end
        repeat (bit_clks) @(posedge core_clk);
        r[9] = serial_out_pin;
        if (sl2) begin
            repeat (bit_clks) @(posedge core_clk);
            r[10] = serial_out_pin;
        end
        got_q.push_back(r);
    end
endmodule
`default_nettype wire

// ### bench/tb.sv
// Purpose: self-checking bench for the serial port configuration block
// Assumes: bench acts as the CPU, remote model drives the receive pin
// Notes: registers are addressed as offsets from the mode register
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int FDEPTH = 8;
    logic core_clk, resetn, cpu_wr, cpu_bit_wr, cpu_bit_val, cpu_rd, tx_valid, tx_ready;
    logic [15:0] cpu_addr;
    logic [7:0] cpu_wdata, tx_data, cpu_rdata;
    logic [2:0] cpu_bit_sel;
    logic serial_in_pin, serial_out_pin, serial_out_en, serial_in_en, tx_done, rx_done, rx_err;
    int mismatches = 0, comparisons = 0, n_done = 0, n_err = 0;
    int seed = 32'h11E8831E;
    logic [10:0] exp_q[$];
    ucbs_top #(.FIFO_DEPTH(FDEPTH)) dut (.*);
    ucbs_remote rem (.*);
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        n_done += int'(rx_done === 1'b1);
        n_err += int'(rx_err === 1'b1);
    end
    task automatic give_verdict();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] r, input logic [7:0] d, input bit bitw, input logic [2:0] s);
        @(posedge core_clk);
        cpu_addr <= ucbs_pkg::ADDR_MODE + 16'(r);
        cpu_wdata <= d;
        cpu_bit_sel <= s;
        cpu_bit_val <= d[0];
        cpu_wr <= !bitw;
        cpu_bit_wr <= bitw;
        @(posedge core_clk);
        cpu_wr <= 1'b0;
        cpu_bit_wr <= 1'b0;
    endtask
    task automatic rc(input logic [2:0] r, input logic [7:0] e);
        @(posedge core_clk);
        cpu_addr <= ucbs_pkg::ADDR_MODE + 16'(r);
        cpu_rd <= 1'b1;
        @(posedge core_clk);
        cpu_rd <= 1'b0;
        @(negedge core_clk);
        chk(cpu_rdata, e);
    endtask
    task automatic push_n(input int n, input bit cl8, input int pm, output int acc);
        logic [7:0] d;
        acc = 0;
        d = 8'($random(seed));
        @(posedge core_clk);
        tx_data <= d;
        tx_valid <= 1'b1;
        for (int w = 0; w < 40 && acc < n; w++) begin
            @(posedge core_clk);
            if (tx_ready === 1'b1) begin
                acc++;
                d[7] &= cl8;
                exp_q.push_back({2'b11, (pm == 3 ? ^d : pm == 2 ? ~^d : 1'b0), d});
                d = 8'($random(seed));
                tx_data <= d;
            end
        end
        tx_valid <= 1'b0;
    endtask
    task automatic rx_step(input logic [7:0] d, input bit bp, input bit bs, input logic [7:0] es,
        input bit rdb);
        rem.send(d, bp, bs);
        rc(3'h1, es);
        if (rdb) begin
            rc(3'h3, d);
            rc(3'h1, 8'h00);
        end
    endtask
    initial begin
        logic [7:0] m;
        int acc, nd, ne;
        {resetn, cpu_wr, cpu_bit_wr, cpu_bit_val, cpu_rd, tx_valid} = 6'h00;
        {cpu_addr, cpu_wdata, tx_data, cpu_bit_sel} = 35'h0;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        for (int r = 0; r < 3; r++)
            rc(3'(r), 8'h00);
        rc(3'h5, 8'h00);
        wr(3'h2, 8'hFF, 1'b0, 3'h0);
        rc(3'h2, 8'h7F);
        wr(3'h2, 8'h00, 1'b1, 3'h0);
        rc(3'h2, 8'h7F);
        wr(3'h1, 8'hFF, 1'b0, 3'h0);
        rc(3'h1, 8'h00);
        wr(3'h0, 8'hFF, 1'b0, 3'h0);
        rc(3'h0, 8'hFE);
        for (int i = 0; i < 8; i++) begin
            wr(3'h0, 8'h00, 1'b1, 3'(i));
            rc(3'h0, 8'hFE & (8'hFF << (i + 1)));
        end
        for (int e = 0; e < 4; e++) begin
            wr(3'h0, {2'(e), 6'h00}, 1'b0, 3'h0);
            @(posedge core_clk);
            @(negedge core_clk);
            chk({serial_out_en, serial_in_en}, 16'(e));
        end
        for (int c = 0; c < 4; c++) begin
            rem.par_mode = c;
            rem.cl8 = c != 2;
            rem.sl2 = c[0];
            rem.bit_clks = (4 << c) * (16 + c);
            m = {2'b00, 2'(c), 1'(c != 2), 1'(c[0]), 2'b00};
            wr(3'h2, 8'(c * 17), 1'b0, 3'h0);
            wr(3'h0, m, 1'b0, 3'h0);
            push_n(c == 0 ? 12 : 2, c != 2, c, acc);
            chk(16'(acc), 16'(c == 0 ? FDEPTH : 2));
            chk(tx_ready, 16'(c != 0));
            wr(3'h0, m | 8'h80, 1'b0, 3'h0);
            for (int w = 0; w < 20000 && rem.got_q.size() < acc; w++)
                @(posedge core_clk);
            repeat (rem.bit_clks * 2) @(posedge core_clk);
            chk(16'(rem.got_q.size()), 16'(acc));
            while (rem.got_q.size() > 0 && exp_q.size() > 0)
                chk(rem.got_q.pop_front(), exp_q.pop_front());
            exp_q.delete();
            wr(3'h0, m, 1'b0, 3'h0);
        end
        wr(3'h2, 8'h00, 1'b0, 3'h0);
        rem.bit_clks = 64;
        rem.cl8 = 1'b1;
        for (int p = 0; p < 4; p++) begin
            rem.par_mode = p;
            wr(3'h0, {2'b01, 2'(p), 4'h8}, 1'b0, 3'h0);
            rx_step(8'($random(seed)), 1'b1, 1'b0, p > 1 ? 8'h04 : 8'h00, 1'b1);
        end
        wr(3'h0, 8'h7C, 1'b0, 3'h0);
        rx_step(8'h3C, 1'b0, 1'b1, 8'h02, 1'b1);
        rx_step(8'h11, 1'b0, 1'b0, 8'h00, 1'b0);
        rx_step(8'h22, 1'b0, 1'b0, 8'h01, 1'b0);
        rx_step(8'h33, 1'b0, 1'b0, 8'h01, 1'b1);
        rx_step(8'h44, 1'b0, 1'b0, 8'h00, 1'b1);
        for (int k = 0; k < 2; k++) begin
            wr(3'h0, 8'(k), 1'b1, 3'h1);
            nd = n_done;
            ne = n_err;
            rx_step(8'h5A, 1'b1, 1'b0, 8'h04, 1'b1);
            chk(16'(n_done - nd), 16'(1 - k));
            chk(16'(n_err - ne), 16'h0001);
        end
        give_verdict();
    end
    initial begin
        repeat (90000) @(posedge core_clk);
        mismatches++;
        give_verdict();
    end
endmodule
`default_nettype wire
